// ===== include/ipm_defs.svh
`ifndef IPM_DEFS_SVH
`define IPM_DEFS_SVH

// ==========================================================================
// Register byte offsets on the Wishbone slave.
// ==========================================================================
`define IPM_OFS_DATA      8'h00
`define IPM_OFS_OWN_ADDR  8'h04
`define IPM_OFS_CTRL      8'h08
`define IPM_OFS_STATUS    8'h0C
`define IPM_OFS_IRQ_VEC   8'h10
`define IPM_OFS_FRAMES    8'h14
`define IPM_OFS_FIRST     8'h18

// ==========================================================================
// Field positions.
// ==========================================================================
`define IPM_CTRL_IRQ_EN   0
`define IPM_ST_PEND_N     0
`define IPM_ST_AAS        1
`define IPM_ST_BUS_FREE   2
`define IPM_ST_MONITOR    3
`define IPM_ST_LAST_ACK   4
`define IPM_ST_OVERRUN    5
`define IPM_ST_UNREAD     6
`define IPM_ST_BUS_ERR    7
`define IPM_ST_BCNT_LSB   8

// ==========================================================================
// Reset values.
// ==========================================================================
`define IPM_OWN_ADDR_RST  7'h00
`define IPM_IRQ_VEC_RST   8'h00
`define IPM_PEND_N_RST    1'h1
`define IPM_BUS_FREE_RST  1'h1

// ==========================================================================
// Counts.
// ==========================================================================
`define IPM_ACK_BIT       4'h8

`endif

// ===== include/ipm_pkg.sv
package ipm_pkg;

  typedef enum logic {
    PH_IDLE,
    PH_XFER
  } ipm_phase_t;

  typedef struct packed {
    logic meta;
    logic stable;
  } ipm_sync_state_t;

  typedef struct packed {
    logic scl_q;
    logic sda_q;
    logic start;
    logic stop;
    logic rise;
  } ipm_cond_state_t;

  typedef struct packed {
    logic        wb_ack;
    logic [31:0] wb_dat;
    logic [6:0]  own_addr;
    logic [7:0]  irq_vec;
    logic        irq_en;
    logic        irq;
    ipm_phase_t  phase;
    logic [3:0]  bitcnt;
    logic [7:0]  shift;
    logic [7:0]  rbuf;
    logic [7:0]  first_byte;
    logic        first_seen;
    logic [7:0]  byte_cnt;
    logic [7:0]  frames;
    logic        pend_n;
    logic        addressed_as_slave_flag;
    logic        bus_free;
    logic        last_ack;
    logic        unread;
    logic        overrun;
    logic        bus_err;
  } ipm_mon_state_t;

endpackage

// ===== logic/ipm_sync.sv
`timescale 1ns/1ns

// Two-stage synchroniser for one asynchronous level.
module ipm_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic async_i,
  input wire logic rst_val_i,
  output logic sync_o
);

  ipm_pkg::ipm_sync_state_t s;
  ipm_pkg::ipm_sync_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.meta = async_i;
    next_s.stable = s.meta;
  end

  // The parent ties the reset level to the idle level of the line.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '{meta: rst_val_i, stable: rst_val_i};
    end else begin
      s <= next_s;
    end
  end

  assign sync_o = s.stable;

endmodule

// ===== logic/ipm_bus_cond.sv
`timescale 1ns/1ns

// Finds START, STOP and SCL rising edges on synchronised bus lines.
module ipm_bus_cond (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic start_o,
  output logic stop_o,
  output logic rise_o
);

  ipm_pkg::ipm_cond_state_t s;
  ipm_pkg::ipm_cond_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.scl_q = scl_i;
    next_s.sda_q = sda_i;
    next_s.start = scl_i & s.scl_q & s.sda_q & ~sda_i;
    next_s.stop = scl_i & s.scl_q & ~s.sda_q & sda_i;
    next_s.rise = scl_i & ~s.scl_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '{scl_q: 1'b1, sda_q: 1'b1, start: 1'b0, stop: 1'b0,
             rise: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign start_o = s.start;
  assign stop_o = s.stop;
  assign rise_o = s.rise;

endmodule

// ===== logic/ipm_monitor.sv
`timescale 1ns/1ns
`include "ipm_defs.svh"

module ipm_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic irq_o
);

  // ========================================================================
  // Bus line synchronisers and condition detection.
  // ========================================================================
  logic scl_s;
  logic sda_s;
  logic bus_start;
  logic bus_stop;
  logic scl_rise;

  ipm_sync u_scl_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(scl_i),
    .rst_val_i(1'b1),
    .sync_o(scl_s)
  );

  ipm_sync u_sda_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(sda_i),
    .rst_val_i(1'b1),
    .sync_o(sda_s)
  );

  ipm_bus_cond u_cond (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .scl_i(scl_s),
    .sda_i(sda_s),
    .start_o(bus_start),
    .stop_o(bus_stop),
    .rise_o(scl_rise)
  );

  // ========================================================================
  // State.
  // ========================================================================
  ipm_pkg::ipm_mon_state_t s;
  ipm_pkg::ipm_mon_state_t next_s;

  logic monitor;
  logic req;
  logic wr_lane0;
  logic sda_now;

  // All-zero own address selects monitor mode; a nonzero write leaves it.
  assign monitor = (s.own_addr == 7'h00);

  // A new request is taken only while ack is low, so ack lasts one cycle.
  assign req = wb_cyc_i & wb_stb_i & ~s.wb_ack;
  assign wr_lane0 = req & wb_we_i & wb_sel_i[0];

  // The bit value is sampled from the stable stage at the clock rise.
  assign sda_now = sda_s;

  // ========================================================================
  // Next-state logic.
  // ========================================================================
  always_comb begin
    next_s = s;
    next_s.wb_ack = 1'b0;

    // ----------------------------------------------------------------------
    // Register writes.
    // ----------------------------------------------------------------------
    if (req) begin
      next_s.wb_ack = 1'b1;
    end
    if (wr_lane0) begin
      if (wb_adr_i == `IPM_OFS_OWN_ADDR) begin
        next_s.own_addr = wb_dat_i[6:0];
      end else if (wb_adr_i == `IPM_OFS_CTRL) begin
        next_s.irq_en = wb_dat_i[`IPM_CTRL_IRQ_EN];
      end else if (wb_adr_i == `IPM_OFS_STATUS) begin
        // Only the sticky error bits clear; the bus-free bit ignores writes.
        if (wb_dat_i[`IPM_ST_OVERRUN]) begin
          next_s.overrun = 1'b0;
        end
        if (wb_dat_i[`IPM_ST_BUS_ERR]) begin
          next_s.bus_err = 1'b0;
        end
      end else if (wb_adr_i == `IPM_OFS_IRQ_VEC) begin
        next_s.irq_vec = wb_dat_i[7:0];
      end else if (wb_adr_i == `IPM_OFS_FRAMES) begin
        next_s.frames = 8'h00;
      end
    end

    // ----------------------------------------------------------------------
    // Register reads; unmapped offsets read as zero.
    // ----------------------------------------------------------------------
    if (req && !wb_we_i) begin
      next_s.wb_dat = 32'h0000_0000;
      if (wb_adr_i == `IPM_OFS_DATA) begin
        next_s.wb_dat[7:0] = s.rbuf;
        next_s.pend_n = 1'b1;
        next_s.unread = 1'b0;
      end else if (wb_adr_i == `IPM_OFS_OWN_ADDR) begin
        next_s.wb_dat[6:0] = s.own_addr;
      end else if (wb_adr_i == `IPM_OFS_CTRL) begin
        next_s.wb_dat[`IPM_CTRL_IRQ_EN] = s.irq_en;
      end else if (wb_adr_i == `IPM_OFS_STATUS) begin
        next_s.wb_dat[`IPM_ST_PEND_N] = s.pend_n;
        next_s.wb_dat[`IPM_ST_AAS] = s.addressed_as_slave_flag;
        next_s.wb_dat[`IPM_ST_BUS_FREE] = s.bus_free;
        next_s.wb_dat[`IPM_ST_MONITOR] = monitor;
        next_s.wb_dat[`IPM_ST_LAST_ACK] = s.last_ack;
        next_s.wb_dat[`IPM_ST_OVERRUN] = s.overrun;
        next_s.wb_dat[`IPM_ST_UNREAD] = s.unread;
        next_s.wb_dat[`IPM_ST_BUS_ERR] = s.bus_err;
        next_s.wb_dat[`IPM_ST_BCNT_LSB +: 8] = s.byte_cnt;
      end else if (wb_adr_i == `IPM_OFS_IRQ_VEC) begin
        next_s.wb_dat[7:0] = s.irq_vec;
      end else if (wb_adr_i == `IPM_OFS_FRAMES) begin
        next_s.wb_dat[7:0] = s.frames;
      end else if (wb_adr_i == `IPM_OFS_FIRST) begin
        next_s.wb_dat[7:0] = s.first_byte;
      end
    end

    // ----------------------------------------------------------------------
    // Bit and byte tracking; bus events are applied after the register
    // accesses so that a hardware set wins over a software clear.
    // ----------------------------------------------------------------------
    if (scl_rise && s.phase == ipm_pkg::PH_XFER && monitor) begin
      if (s.bitcnt == 4'h0) begin
        next_s.pend_n = 1'b1;
      end
      if (s.bitcnt < `IPM_ACK_BIT) begin
        // Every byte is received, whatever the address.
        next_s.shift = {s.shift[6:0], sda_now};
        next_s.bitcnt = s.bitcnt + 4'h1;
      end else begin
        // Ninth clock: acknowledge bit seen, byte is handed over.
        next_s.last_ack = sda_now;
        next_s.rbuf = s.shift;
        next_s.pend_n = 1'b0;
        next_s.addressed_as_slave_flag = 1'b0;
        next_s.bitcnt = 4'h0;
        next_s.byte_cnt = s.byte_cnt + 8'h01;
        if (s.unread) begin
          next_s.overrun = 1'b1;
        end
        next_s.unread = 1'b1;
        if (!s.first_seen) begin
          next_s.first_byte = s.shift;
          next_s.first_seen = 1'b1;
        end
      end
    end

    // ----------------------------------------------------------------------
    // START and STOP conditions.
    // ----------------------------------------------------------------------
    if (bus_start) begin
      if (s.phase == ipm_pkg::PH_XFER && s.bitcnt > 4'h1 && monitor) begin
        next_s.bus_err = 1'b1;
      end
      next_s.phase = ipm_pkg::PH_XFER;
      next_s.bitcnt = 4'h0;
      next_s.bus_free = 1'b0;
      if (monitor) begin
        next_s.addressed_as_slave_flag = 1'b1;
        next_s.byte_cnt = 8'h00;
        next_s.first_seen = 1'b0;
      end
    end else if (bus_stop) begin
      if (s.phase == ipm_pkg::PH_XFER && s.bitcnt > 4'h1 && monitor) begin
        next_s.bus_err = 1'b1;
      end
      next_s.phase = ipm_pkg::PH_IDLE;
      next_s.bitcnt = 4'h0;
      next_s.bus_free = 1'b1;
      if (monitor) begin
        next_s.frames = s.frames + 8'h01;
      end
    end

    // ----------------------------------------------------------------------
    // Interrupt request: only outside monitor mode.
    // ----------------------------------------------------------------------
    next_s.irq = ~monitor & s.irq_en & ~s.pend_n;
  end

  // ========================================================================
  // State register.
  // ========================================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.own_addr <= `IPM_OWN_ADDR_RST;
      s.irq_vec <= `IPM_IRQ_VEC_RST;
      s.pend_n <= `IPM_PEND_N_RST;
      s.bus_free <= `IPM_BUS_FREE_RST;
      s.phase <= ipm_pkg::PH_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ========================================================================
  // Outputs.
  // ========================================================================
  assign wb_dat_o = s.wb_dat;
  assign wb_ack_o = s.wb_ack;
  assign irq_o = s.irq;

  // The lines are only ever released: no clock stretch on a pending byte
  // and no acknowledge pulled in, so the block stays invisible on the bus.
  assign scl_o = 1'b0;
  assign scl_oe_n_o = 1'b1;
  assign sda_o = 1'b0;
  assign sda_oe_n_o = 1'b1;

endmodule

// ===== verification/ipm_chk.sv
`timescale 1ns/1ns
`include "ipm_defs.svh"

// ==========================================================================
// Port checker for the bus monitor.
module ipm_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic scl_i,
  input wire logic scl_oe_n_o,
  input wire logic sda_i,
  input wire logic sda_oe_n_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [6:0] own;
  logic bfree, sq, dq;
  wire rd = wb_ack_o && !wb_we_i;
  wire st = rd && wb_adr_i == `IPM_OFS_STATUS;
  // Tracks the own address and the line state as the host expects them.
  always_ff @(posedge clk_i) begin
    sq <= scl_i;
    dq <= sda_i;
    if (rst_i) begin
      own <= 7'h00;
      bfree <= 1'b1;
    end else begin
      if (wb_ack_o && wb_we_i && wb_sel_i[0]
          && wb_adr_i == `IPM_OFS_OWN_ADDR) begin
        own <= wb_dat_i[6:0];
      end
      if (sq && scl_i && dq && !sda_i) begin
        bfree <= 1'b0;
      end
      if (sq && scl_i && !dq && sda_i) begin
        bfree <= 1'b1;
      end
    end
  end
  a_sda_released: assert property (
    own == 7'h00 |-> sda_oe_n_o)
    else $error("data line driven in monitor mode");
  a_scl_released: assert property (
    own == 7'h00 |-> scl_oe_n_o)
    else $error("clock line driven in monitor mode");
  a_irq_quiet: assert property (own == 7'h00 |-> !irq_o)
    else $error("interrupt raised in monitor mode");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property ($rose(wb_ack_o) |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_mode_flag: assert property (
    st |-> wb_dat_o[3] == (own == 7'h00))
    else $error("monitor flag wrong");
  a_own_read: assert property (
    rd && wb_adr_i == `IPM_OFS_OWN_ADDR |-> wb_dat_o[6:0] == own)
    else $error("own address readback wrong");
  a_bus_free: assert property (st |-> wb_dat_o[2] == bfree)
    else $error("bus free flag wrong");
endmodule

bind ipm_monitor ipm_chk i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .scl_i,
  .scl_oe_n_o, .sda_i, .sda_oe_n_o, .irq_o);

// ===== verification/ipm_i2c_mst.sv
`timescale 1ns/1ns

// ==========================================================================
// Far-side master; a low output pulls the line, a high one releases it.
module ipm_i2c_mst (
  input wire logic clk_i,
  output logic scl_o,
  output logic sda_o
);
  logic scl_r = 1'b1, sda_r = 1'b1;
  assign scl_o = scl_r;
  assign sda_o = sda_r;
  task automatic hp(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One bit in a 160 ns link clock period.
  task automatic bit_(input logic b);
    sda_r <= b;
    hp(2);
    scl_r <= 1'b1;
    hp(4);
    scl_r <= 1'b0;
    hp(2);
  endtask
  task automatic start;
    sda_r <= 1'b1;
    hp(2);
    scl_r <= 1'b1;
    hp(4);
    sda_r <= 1'b0;
    hp(4);
    scl_r <= 1'b0;
    hp(4);
  endtask
  task automatic stop;
    sda_r <= 1'b0;
    hp(2);
    scl_r <= 1'b1;
    hp(4);
    sda_r <= 1'b1;
    hp(8);
  endtask
  // Sends the low n bits of d, then the acknowledge of another slave.
  task automatic send(input logic [7:0] d, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      bit_(d[i]);
    end
    bit_(1'b0);
    hp(4);
  endtask
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ns
`include "ipm_defs.svh"

module tb_top;
  logic clk_i, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, dat_o, rdat;
  logic ack, scl_oe_n, sda_oe_n, scl_d, sda_d, irq, m_scl, m_sda;
  wire scl = m_scl & (scl_oe_n | scl_d);
  wire sda = m_sda & (sda_oe_n | sda_d);
  int err_count, compares;
  ipm_monitor i_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .scl_i(scl), .scl_o(scl_d),
    .scl_oe_n_o(scl_oe_n), .sda_i(sda), .sda_o(sda_d),
    .sda_oe_n_o(sda_oe_n), .irq_o(irq));
  ipm_i2c_mst i_bus (.clk_i, .scl_o(m_scl), .sda_o(m_sda));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // ========================================================================
  // Shared tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Checks monitor, bus free, addressed and pending flags.
  task automatic st(input logic [3:0] e);
    wb(1'b0, `IPM_OFS_STATUS, 32'h0);
    chk(rdat[3:0], e);
  endtask
  task automatic rdd(input logic [7:0] e);
    wb(1'b0, `IPM_OFS_DATA, 32'h0);
    chk(rdat, {24'h0, e});
  endtask
  // ========================================================================
  // Scenarios.
  task automatic t_reset;
    wb(1'b0, `IPM_OFS_OWN_ADDR, 32'h0);
    chk(rdat, 32'h0);
    wb(1'b0, `IPM_OFS_IRQ_VEC, 32'h0);
    chk(rdat, 32'h0);
    wb(1'b1, `IPM_OFS_STATUS, 32'h0);
    st(4'hD);
    wb(1'b0, 8'h1C, 32'h0);
    chk(rdat, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_frame;
    wb(1'b1, `IPM_OFS_CTRL, 32'h1);
    i_bus.start();
    st(4'hB);
    i_bus.send(8'hA5, 8);
    st(4'h8);
    chk(scl_oe_n, 1'b1);
    chk(irq, 1'b0);
    rdd(8'hA5);
    st(4'h9);
    i_bus.send(8'h3C, 8);
    i_bus.bit_(1'b1);
    i_bus.hp(4);
    st(4'h9);
    rdd(8'h3C);
    i_bus.send(8'hC3, 7);
    st(4'h8);
    rdd(8'hC3);
    i_bus.start();
    st(4'hB);
    i_bus.send(8'h5A, 8);
    st(4'h8);
    rdd(8'h5A);
    i_bus.stop();
    st(4'hD);
    wb(1'b0, `IPM_OFS_STATUS, 32'h0);
    chk(rdat, 32'h0000_010D);
    wb(1'b0, `IPM_OFS_FRAMES, 32'h0);
    chk(rdat, 32'h0000_0001);
    wb(1'b0, `IPM_OFS_FIRST, 32'h0);
    chk(rdat, 32'h0000_005A);
    $display("test frame done");
  endtask
  task automatic t_leave;
    wb(1'b1, `IPM_OFS_OWN_ADDR, 32'h55);
    st(4'h5);
    wb(1'b1, `IPM_OFS_OWN_ADDR, 32'h0);
    st(4'hD);
    $display("test leave done");
  endtask
  task automatic final_report;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_frame();
    t_leave();
    final_report();
  end
endmodule
